/* File: rtl/ccfu_compare.sv */
// Flag computation of the compare instructions.
`timescale 1ns/1ns
module ccfu_compare (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic with_carry,
  input wire logic [7:0] flags_in,
  output logic [7:0] flags_out
);
  logic [7:0] res;
  logic borrow_in;
  logic zero;
  logic ovf;
  assign borrow_in = with_carry & flags_in[ccfu_pkg::FLAG_C];
  assign res = a - b - {7'h00, borrow_in};
  // With carry the zero flag can only stay set, so multi-byte compares chain.
  assign zero = (res == 8'h00) & (~with_carry | flags_in[ccfu_pkg::FLAG_Z]);
  assign ovf = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
  always_comb begin
    flags_out = flags_in;
    flags_out[ccfu_pkg::FLAG_C] = (~a[7] & b[7]) | (b[7] & res[7]) | (res[7] & ~a[7]);
    flags_out[ccfu_pkg::FLAG_Z] = zero;
    flags_out[ccfu_pkg::FLAG_N] = res[7];
    flags_out[ccfu_pkg::FLAG_V] = ovf;
    flags_out[ccfu_pkg::FLAG_S] = res[7] ^ ovf;
    flags_out[ccfu_pkg::FLAG_H] = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
  end
endmodule // ccfu_compare

/* File: rtl/ccfu_control_flow.sv */
// Control-flow unit: jumps, calls, returns, compares, skips and branches.
`timescale 1ns/1ns
// Function
// RULE1: indirect_jump loads pc from pointer pair, flags untouched, two cycles.
// RULE2: indirect_call pushes return address, loads pc from pointer, three cycles.
// RULE3: compare_skip_equal skips next when equal; pc +2 or +3, 1/2/3 cycles.
// RULE4: compares only update Z N V C H flags, no register write, one cycle; the code also updates S.
// RULE5: skip_reg_bit_clear skips next when selected register bit is 0.
// RULE6: skip_reg_bit_set skips next when selected register bit is 1.
// RULE7: skip_io_bit_clear skips next when selected I/O bit is 0.
// RULE8: skip_io_bit_set skips next when selected I/O bit is 1.
// RULE9: branch_flag_set jumps pc+k+1 when flag is 1; 1 or 2 cycles.
// RULE10: branch_flag_clear jumps pc+k+1 when flag is 0; 1 or 2 cycles.
// RULE11: branch_carry_clear branches when carry is 0, 1 or 2 cycles.
// RULE12: branch_same_higher behaves exactly like branch_carry_clear.
// RULE13: branch_signed_ge branches when negative xor overflow is 0.
// RULE14: branch_signed_lt is a relative branch costing 1 or 2 cycles.
// RULE15: branch_signed_lt is taken when negative xor overflow is 1.
// RULE16: relative_jump pc+k+1 in 2 cycles; relative_call pushes first, 3 cycles.
// RULE17: returns pop pc in 4 cycles; interrupt_return also sets interrupt enable.
module ccfu_control_flow (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic next_two_word,
  output logic instr_ready,
  output logic [4:0] rd_addr,
  output logic [4:0] rr_addr,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  output logic [4:0] io_addr,
  input wire logic [7:0] io_val,
  input wire logic [15:0] pointer_val,
  input wire logic [7:0] status_flags,
  output logic status_flags_we,
  output logic [7:0] status_flags_new,
  output logic stack_push,
  output logic [15:0] stack_push_data,
  output logic stack_pop,
  input wire logic [15:0] stack_pop_data,
  output logic [15:0] pc
);
  function automatic logic op_match(input logic [15:0] word, input logic [15:0] pattern,
                                    input logic [15:0] mask);
    op_match = (word & mask) == pattern;
  endfunction

  ccfu_pkg::ccfu_state_t state_q;
  ccfu_pkg::ccfu_state_t state_d;
  logic [1:0] stall_q;
  logic [1:0] stall_d;
  logic [15:0] pc_q;
  logic [15:0] pc_d;
  logic flags_we_q;
  logic [7:0] flags_q;
  logic push_q;
  logic [15:0] push_data_q;

  wire take = instr_valid & (state_q == ccfu_pkg::ST_RUN);
  wire is_rel_jump = op_match(instr, ccfu_pkg::OP_RELATIVE_JUMP, ccfu_pkg::MSK_RELATIVE_JUMP);
  wire is_rel_call = op_match(instr, ccfu_pkg::OP_RELATIVE_CALL, ccfu_pkg::MSK_RELATIVE_CALL);
  wire is_ind_jump = op_match(instr, ccfu_pkg::OP_INDIRECT_JUMP, ccfu_pkg::MSK_FULL);
  wire is_ind_call = op_match(instr, ccfu_pkg::OP_INDIRECT_CALL, ccfu_pkg::MSK_FULL);
  wire is_sub_return = op_match(instr, ccfu_pkg::OP_SUBROUTINE_RETURN, ccfu_pkg::MSK_FULL);
  wire is_int_return = op_match(instr, ccfu_pkg::OP_INTERRUPT_RETURN, ccfu_pkg::MSK_FULL);
  wire is_cmp_skip = op_match(instr, ccfu_pkg::OP_COMPARE_SKIP_EQUAL, ccfu_pkg::MSK_REG_PAIR);
  wire is_cmp_regs = op_match(instr, ccfu_pkg::OP_COMPARE_REGS, ccfu_pkg::MSK_REG_PAIR);
  wire is_cmp_carry = op_match(instr, ccfu_pkg::OP_COMPARE_REGS_CARRY, ccfu_pkg::MSK_REG_PAIR);
  wire is_cmp_imm = op_match(instr, ccfu_pkg::OP_COMPARE_IMMEDIATE, ccfu_pkg::MSK_IMMEDIATE);
  wire is_skip_rclr = op_match(instr, ccfu_pkg::OP_SKIP_REG_BIT_CLEAR, ccfu_pkg::MSK_SKIP_REG);
  wire is_skip_rset = op_match(instr, ccfu_pkg::OP_SKIP_REG_BIT_SET, ccfu_pkg::MSK_SKIP_REG);
  wire is_skip_ioclr = op_match(instr, ccfu_pkg::OP_SKIP_IO_BIT_CLEAR, ccfu_pkg::MSK_SKIP_IO);
  wire is_skip_ioset = op_match(instr, ccfu_pkg::OP_SKIP_IO_BIT_SET, ccfu_pkg::MSK_SKIP_IO);
  wire is_br_set = op_match(instr, ccfu_pkg::OP_BRANCH_FLAG_SET, ccfu_pkg::MSK_BRANCH);
  wire is_br_clr = op_match(instr, ccfu_pkg::OP_BRANCH_FLAG_CLEAR, ccfu_pkg::MSK_BRANCH);
  wire is_compare = is_cmp_regs | is_cmp_carry | is_cmp_imm;

  // Operand selection toward the register file and I/O space.
  wire [7:0] imm_val = {instr[11:8], instr[3:0]};
  assign rd_addr = is_cmp_imm ? {1'b1, instr[7:4]} : instr[8:4];
  assign rr_addr = {instr[9], instr[3:0]};
  assign io_addr = instr[7:3];
  wire [2:0] bit_sel = instr[2:0];

  // Skip decisions; the skip distance follows the length of the next instruction.
  wire skip = (is_cmp_skip & (rd_val == rr_val)) // see RULE3
    | (is_skip_rclr & ~rd_val[bit_sel]) // see RULE5
    | (is_skip_rset & rd_val[bit_sel]) // see RULE6
    | (is_skip_ioclr & ~io_val[bit_sel]) // see RULE7
    | (is_skip_ioset & io_val[bit_sel]); // see RULE8
  wire is_skip_op = is_cmp_skip | is_skip_rclr | is_skip_rset | is_skip_ioclr | is_skip_ioset;

  // The sign slot is rebuilt from N and V so signed branches never trust a stale S bit.
  wire [7:0] eff_flags = {status_flags[7:5],
                          status_flags[ccfu_pkg::FLAG_N] ^ status_flags[ccfu_pkg::FLAG_V],
                          status_flags[3:0]}; // see RULE13 RULE15
  wire sel_flag = eff_flags[bit_sel];
  // Carry-clear, same-or-higher and signed-ge are flag-clear branches on C or S.
  wire br_taken = (is_br_set & sel_flag) // see RULE9 RULE14 RULE15
    | (is_br_clr & ~sel_flag); // see RULE10 RULE11 RULE12 RULE13

  wire [15:0] pc_next = pc_q + 16'h0001;
  wire [15:0] pc_skip = next_two_word ? pc_q + 16'h0003 : pc_q + 16'h0002;
  wire [15:0] rel_long = {{4{instr[11]}}, instr[11:0]};
  wire [15:0] rel_short = {{9{instr[9]}}, instr[9:3]};
  wire [15:0] pc_rel_long = pc_next + rel_long;
  wire [15:0] pc_rel_short = pc_next + rel_short;

  logic [15:0] pc_tgt;
  logic [2:0] cycles;
  always_comb begin
    pc_tgt = pc_next;
    cycles = ccfu_pkg::CYC_SINGLE;
    if (is_rel_jump) begin
      pc_tgt = pc_rel_long; // see RULE16
      cycles = ccfu_pkg::CYC_JUMP;
    end else if (is_rel_call) begin
      pc_tgt = pc_rel_long; // see RULE16
      cycles = ccfu_pkg::CYC_CALL;
    end else if (is_ind_jump) begin
      pc_tgt = pointer_val; // see RULE1
      cycles = ccfu_pkg::CYC_JUMP;
    end else if (is_ind_call) begin
      pc_tgt = pointer_val; // see RULE2
      cycles = ccfu_pkg::CYC_CALL;
    end else if (is_sub_return | is_int_return) begin
      pc_tgt = pc_q;
      cycles = ccfu_pkg::CYC_RETURN; // see RULE17
    end else if (is_skip_op & skip) begin
      pc_tgt = pc_skip; // see RULE3
      cycles = next_two_word ? ccfu_pkg::CYC_SKIP_LONG : ccfu_pkg::CYC_SKIP_SHORT;
    end else if ((is_br_set | is_br_clr) & br_taken) begin
      pc_tgt = pc_rel_short; // see RULE9 RULE10
      cycles = ccfu_pkg::CYC_BRANCH_TAKEN;
    end
  end

  // Compare results go out as a full flag byte; I and T pass through unchanged.
  logic [7:0] cmp_flags;
  ccfu_compare u_compare (
    .a(rd_val),
    .b(is_cmp_imm ? imm_val : rr_val),
    .with_carry(is_cmp_carry),
    .flags_in(status_flags),
    .flags_out(cmp_flags)
  );

  always_comb begin
    state_d = state_q;
    stall_d = stall_q;
    pc_d = pc_q;
    case (state_q)
      ccfu_pkg::ST_RUN: begin
        if (take) begin
          pc_d = pc_tgt;
          if (is_sub_return | is_int_return) begin
            state_d = ccfu_pkg::ST_POP; // see RULE17
          end else if (cycles != ccfu_pkg::CYC_SINGLE) begin
            state_d = ccfu_pkg::ST_STALL;
            stall_d = 2'(cycles - 3'h2);
          end
        end
      end
      ccfu_pkg::ST_POP: begin
        pc_d = stack_pop_data; // see RULE17
        state_d = ccfu_pkg::ST_STALL;
        stall_d = ccfu_pkg::RETURN_TAIL;
      end
      ccfu_pkg::ST_STALL: begin
        if (stall_q == 2'h0) begin
          state_d = ccfu_pkg::ST_RUN;
        end else begin
          stall_d = stall_q - 2'h1;
        end
      end
      default: begin
        state_d = ccfu_pkg::ST_RUN;
        stall_d = 2'h0;
      end
    endcase
  end

  // Only compares and the interrupt return write flags; all jumps leave them alone.
  logic int_return_q;
  wire flags_we_d = (take & is_compare) // see RULE4
    | (state_q == ccfu_pkg::ST_POP & int_return_q); // see RULE17
  logic [7:0] int_return_flags;
  always_comb begin
    int_return_flags = status_flags;
    int_return_flags[ccfu_pkg::FLAG_I] = 1'b1; // see RULE17
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ccfu_pkg::ST_RUN;
      stall_q <= 2'h0;
      pc_q <= ccfu_pkg::PC_RESET;
      int_return_q <= 1'b0;
    end else begin
      state_q <= state_d;
      stall_q <= stall_d;
      pc_q <= pc_d;
      if (take) begin
        int_return_q <= is_int_return;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flags_we_q <= 1'b0;
      flags_q <= ccfu_pkg::FLAGS_RESET;
    end else begin
      flags_we_q <= flags_we_d;
      if (take & is_compare) begin
        flags_q <= cmp_flags; // see RULE4
      end else if (state_q == ccfu_pkg::ST_POP & int_return_q) begin
        flags_q <= int_return_flags;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      push_q <= 1'b0;
      push_data_q <= ccfu_pkg::PC_RESET;
    end else begin
      push_q <= take & (is_rel_call | is_ind_call); // see RULE2 RULE16
      if (take) begin
        push_data_q <= pc_next;
      end
    end
  end

  assign instr_ready = state_q == ccfu_pkg::ST_RUN;
  assign stack_pop = take & (is_sub_return | is_int_return); // see RULE17
  assign status_flags_we = flags_we_q;
  assign status_flags_new = flags_q;
  assign stack_push = push_q;
  assign stack_push_data = push_data_q;
  assign pc = pc_q;
endmodule // ccfu_control_flow

/* File: rtl/ccfu_pkg.sv */
// Constants, opcode patterns and state type of the control-flow unit.
package ccfu_pkg;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  // Status flag bit positions.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_I = 7;
  // Opcode patterns and the masks of their fixed bits.
  localparam logic [15:0] OP_RELATIVE_JUMP = 16'hc000;
  localparam logic [15:0] MSK_RELATIVE_JUMP = 16'hf000;
  localparam logic [15:0] OP_RELATIVE_CALL = 16'hd000;
  localparam logic [15:0] MSK_RELATIVE_CALL = 16'hf000;
  localparam logic [15:0] OP_INDIRECT_JUMP = 16'h9409;
  localparam logic [15:0] OP_INDIRECT_CALL = 16'h9509;
  localparam logic [15:0] OP_SUBROUTINE_RETURN = 16'h9508;
  localparam logic [15:0] OP_INTERRUPT_RETURN = 16'h9518;
  localparam logic [15:0] MSK_FULL = 16'hffff;
  localparam logic [15:0] OP_COMPARE_SKIP_EQUAL = 16'h1000;
  localparam logic [15:0] OP_COMPARE_REGS = 16'h1400;
  localparam logic [15:0] OP_COMPARE_REGS_CARRY = 16'h0400;
  localparam logic [15:0] MSK_REG_PAIR = 16'hfc00;
  localparam logic [15:0] OP_COMPARE_IMMEDIATE = 16'h3000;
  localparam logic [15:0] MSK_IMMEDIATE = 16'hf000;
  localparam logic [15:0] OP_SKIP_REG_BIT_CLEAR = 16'hfc00;
  localparam logic [15:0] OP_SKIP_REG_BIT_SET = 16'hfe00;
  localparam logic [15:0] MSK_SKIP_REG = 16'hfe08;
  localparam logic [15:0] OP_SKIP_IO_BIT_CLEAR = 16'h9900;
  localparam logic [15:0] OP_SKIP_IO_BIT_SET = 16'h9b00;
  localparam logic [15:0] MSK_SKIP_IO = 16'hff00;
  localparam logic [15:0] OP_BRANCH_FLAG_SET = 16'hf000;
  localparam logic [15:0] OP_BRANCH_FLAG_CLEAR = 16'hf400;
  localparam logic [15:0] MSK_BRANCH = 16'hfc00;
  // Cycle counts of each instruction group.
  localparam logic [2:0] CYC_JUMP = 3'h2;
  localparam logic [2:0] CYC_CALL = 3'h3;
  localparam logic [2:0] CYC_RETURN = 3'h4;
  localparam logic [2:0] CYC_SINGLE = 3'h1;
  localparam logic [2:0] CYC_BRANCH_TAKEN = 3'h2;
  localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
  localparam logic [2:0] CYC_SKIP_LONG = 3'h3;
  // Stall count loaded after the pop cycle of a return; it counts down to 0, giving two stall cycles.
  localparam logic [1:0] RETURN_TAIL = 2'h1;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STALL = 2'b01,
    ST_POP = 2'b10
  } ccfu_state_t;
endpackage

/* File: verification/ccfu_cf_asserts.sv */
// Concurrent checks on the ports of the control-flow unit.
`timescale 1ns/1ns
module ccfu_cf_asserts (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic next_two_word,
  input wire logic instr_ready,
  input wire logic [7:0] rd_val,
  input wire logic [7:0] rr_val,
  input wire logic [15:0] pointer_val,
  input wire logic [7:0] status_flags,
  input wire logic status_flags_we,
  input wire logic [7:0] status_flags_new,
  input wire logic stack_push,
  input wire logic [15:0] stack_push_data,
  input wire logic stack_pop,
  input wire logic [15:0] stack_pop_data,
  input wire logic [15:0] pc
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  wire logic take = instr_valid && instr_ready;
  wire logic [15:0] rel_tgt = pc + {{4{instr[11]}}, instr[11:0]} + 16'h1;
  wire logic [15:0] br_tgt = pc + {{9{instr[9]}}, instr[9:3]} + 16'h1;
  wire logic is_return = take && (instr == ccfu_pkg::OP_SUBROUTINE_RETURN ||
    instr == ccfu_pkg::OP_INTERRUPT_RETURN);
  wire logic is_cmp = take && (instr[15:10] == 6'h05 || instr[15:10] == 6'h01 ||
    instr[15:12] == 4'h3);
  sequence stall1;
    !instr_ready ##1 instr_ready;
  endsequence
  sequence stall3;
    !instr_ready [*3] ##1 instr_ready;
  endsequence
  a_ind_jump_target: assert property (take && instr == ccfu_pkg::OP_INDIRECT_JUMP |=>
    pc == $past(pointer_val) ##0 stall1) else $error("indirect jump target or timing");
  a_call_push: assert property (take && (instr[15:12] == 4'hd ||
    instr == ccfu_pkg::OP_INDIRECT_CALL) |=> stack_push &&
    stack_push_data == $past(pc) + 16'h1 && !instr_ready ##1 stall1)
    else $error("call push or timing wrong");
  a_rel_jump_target: assert property (take && instr[15:12] == 4'hc |=>
    pc == $past(rel_tgt) && !instr_ready) else $error("relative jump target wrong");
  a_return_pop: assert property (is_return |-> stack_pop ##1 stall3)
    else $error("return pop or timing wrong");
  a_return_pc: assert property (is_return |-> ##2 pc == $past(stack_pop_data))
    else $error("return pc wrong");
  a_ien_set: assert property (take && instr == ccfu_pkg::OP_INTERRUPT_RETURN |->
    ##2 status_flags_we && status_flags_new[ccfu_pkg::FLAG_I]) else $error("interrupt_return flag");
  a_cmp_single: assert property (is_cmp |=> status_flags_we && instr_ready &&
    pc == $past(pc) + 16'h1) else $error("compare not single cycle");
  a_eq_skip: assert property (take && instr[15:10] == 6'h04 && rd_val == rr_val &&
    !next_two_word |=> pc == $past(pc) + 16'h2 ##0 stall1) else $error("skip wrong");
  a_signed_lt: assert property (take && instr[15:10] == 6'h3c && instr[2:0] == 3'h4 &&
    (status_flags[2] ^ status_flags[3]) |=> pc == $past(br_tgt) ##0 stall1)
    else $error("signed branch not taken");
endmodule // ccfu_cf_asserts

/* File: verification/ccfu_control_flow_tb_top.sv */
// Bench of the control-flow unit with its far-side model.
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
  end
module ccfu_control_flow_tb_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic instr_valid = 1'b0;
  logic next_two_word = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic instr_ready, status_flags_we, stack_push, stack_pop, we_seen;
  logic [15:0] pc, pointer_val, stack_push_data, stack_pop_data, cur, push_d;
  logic [4:0] rd_addr, rr_addr, io_addr;
  logic [7:0] rd_val, rr_val, io_val, status_flags, status_flags_new, fl_seen;
  int failures = 0;
  int samples_checked = 0;
  always #4 ref_clk = ~ref_clk;
  ccfu_control_flow ccfu_control_flow_inst (.ref_clk, .resetn, .instr_valid, .instr,
    .next_two_word, .instr_ready, .rd_addr, .rr_addr, .rd_val, .rr_val, .io_addr, .io_val,
    .pointer_val, .status_flags, .status_flags_we, .status_flags_new, .stack_push,
    .stack_push_data, .stack_pop, .stack_pop_data, .pc);
  ccfu_partner ccfu_partner_inst (.ref_clk, .rd_addr, .rr_addr, .rd_val, .rr_val, .io_addr,
    .io_val, .pointer_val, .status_flags, .status_flags_we, .status_flags_new, .stack_push,
    .stack_push_data, .stack_pop, .stack_pop_data);
  task automatic stop_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic set_fl(input logic [7:0] f);
    ccfu_partner_inst.status_flags = f;
  endtask
  // One idle cycle follows each instruction so the flag write lands before the next take.
  task automatic run(input logic [15:0] op, input logic ntw, input logic [15:0] exp_pc,
      input int exp_cyc);
    int n;
    instr = op;
    next_two_word = ntw;
    instr_valid = 1'b1;
    we_seen = 1'b0;
    push_d = 16'hffff;
    @(posedge ref_clk);
    #1;
    instr_valid = 1'b0;
    for (n = 1; n < 8; n++) begin
      if (status_flags_we === 1'b1) begin
        we_seen = 1'b1;
        fl_seen = status_flags_new;
      end
      if (stack_push === 1'b1) begin
        push_d = stack_push_data;
      end
      if (instr_ready === 1'b1) begin
        break;
      end
      @(posedge ref_clk);
      #1;
    end
    if (n == 8) begin
      failures++;
      stop_test();
    end
    `CHK("cycles", exp_cyc, n)
    `CHK("pc", exp_pc, pc)
    cur = exp_pc;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic t_jumps();
    run(16'hc005, 1'b0, cur + 16'h6, 2);
    run(16'hc800, 1'b0, cur - 16'h7ff, 2);
    ccfu_partner_inst.pointer_val = 16'h0123;
    run(ccfu_pkg::OP_INDIRECT_JUMP, 1'b0, 16'h0123, 2);
    `CHK("flag_write", 1'b0, we_seen)
  endtask
  task automatic t_calls();
    ccfu_partner_inst.pointer_val = 16'h0200;
    run(16'hd010, 1'b0, 16'h0134, 3);
    `CHK("push_data", 16'h0124, push_d)
    run(ccfu_pkg::OP_INDIRECT_CALL, 1'b0, 16'h0200, 3);
    `CHK("push_data", 16'h0135, push_d)
    set_fl(8'h00);
    run(ccfu_pkg::OP_SUBROUTINE_RETURN, 1'b0, 16'h0135, 4);
    run(ccfu_pkg::OP_INTERRUPT_RETURN, 1'b0, 16'h0124, 4);
    `CHK("flags", 8'h80, fl_seen)
  endtask
  task automatic t_compares();
    run(16'h1412, 1'b0, cur + 16'h1, 1);
    `CHK("flags", 8'hb5, fl_seen)
    run(16'h0455, 1'b0, cur + 16'h1, 1);
    `CHK("flags", 8'hb5, fl_seen)
    run(16'h3111, 1'b0, cur + 16'h1, 1);
    `CHK("flags", 8'h82, fl_seen)
  endtask
  task automatic t_skips();
    run(16'h1011, 1'b0, cur + 16'h2, 2);
    run(16'h1011, 1'b1, cur + 16'h3, 3);
    run(16'h1012, 1'b1, cur + 16'h1, 1);
    run(16'hfc20, 1'b0, cur + 16'h2, 2);
    run(16'hfc21, 1'b0, cur + 16'h1, 1);
    run(16'hfe21, 1'b1, cur + 16'h3, 3);
    run(16'hfe20, 1'b1, cur + 16'h1, 1);
    run(16'h9922, 1'b0, cur + 16'h1, 1);
    run(16'h9920, 1'b1, cur + 16'h3, 3);
    run(16'h9b22, 1'b0, cur + 16'h2, 2);
  endtask
  task automatic t_branches();
    logic [7:0] f;
    logic tk;
    for (int s = 0; s < 8; s++) begin
      f = 8'h01 << s;
      tk = (s == 4) ? (f[2] ^ f[3]) : f[s];
      set_fl(f);
      run(16'hf018 | 16'(s), 1'b0, tk ? cur + 16'h4 : cur + 16'h1, tk ? 2 : 1);
      set_fl(8'h00);
      run(16'hf7f0 | 16'(s), 1'b0, cur - 16'h1, 2);
    end
    set_fl(8'h04);
    run(16'hf01c, 1'b0, cur + 16'h4, 2);
    run(16'hf41c, 1'b0, cur + 16'h1, 1);
    set_fl(8'h0c);
    run(16'hf41c, 1'b0, cur + 16'h4, 2);
    run(16'hf01c, 1'b0, cur + 16'h1, 1);
    set_fl(8'h01);
    run(16'hf7f0, 1'b0, cur + 16'h1, 1);
  endtask
  initial begin
    cur = 16'h0000;
    repeat (4) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    `CHK("pc", 16'h0000, pc)
    t_jumps();
    t_calls();
    t_compares();
    t_skips();
    t_branches();
    stop_test();
  end
endmodule // ccfu_control_flow_tb_top
bind ccfu_control_flow ccfu_cf_asserts ccfu_cf_asserts_inst (.ref_clk, .resetn, .instr_valid,
  .instr, .next_two_word, .instr_ready, .rd_val, .rr_val, .pointer_val, .status_flags,
  .status_flags_we, .status_flags_new, .stack_push, .stack_push_data, .stack_pop,
  .stack_pop_data, .pc);

/* File: verification/ccfu_partner.sv */
// Far-side model: register file, I/O space, pointer, status flags and stack.
`timescale 1ns/1ns
module ccfu_partner (
  input wire logic ref_clk,
  input wire logic [4:0] rd_addr,
  input wire logic [4:0] rr_addr,
  output logic [7:0] rd_val,
  output logic [7:0] rr_val,
  input wire logic [4:0] io_addr,
  output logic [7:0] io_val,
  output logic [15:0] pointer_val,
  output logic [7:0] status_flags,
  input wire logic status_flags_we,
  input wire logic [7:0] status_flags_new,
  input wire logic stack_push,
  input wire logic [15:0] stack_push_data,
  input wire logic stack_pop,
  output logic [15:0] stack_pop_data
);
  logic [7:0] regs [32];
  logic [15:0] stk [16];
  logic [3:0] sp_q;
  assign rd_val = regs[rd_addr];
  assign rr_val = regs[rr_addr];
  assign io_val = 8'(io_addr);
  initial begin
    foreach (regs[i]) regs[i] = 8'(i);
    sp_q = 4'h0;
    pointer_val = 16'h0000;
    status_flags = 8'h00;
    stack_pop_data = 16'h0000;
  end
  // Popped data stands one cycle, then flips so a late sample is caught.
  always @(posedge ref_clk) begin
    if (status_flags_we) begin
      status_flags <= status_flags_new;
    end
    if (stack_push) begin
      stk[sp_q] <= stack_push_data;
      sp_q <= sp_q + 4'h1;
    end
    if (stack_pop) begin
      sp_q <= sp_q - 4'h1;
    end
    stack_pop_data <= stack_pop ? stk[sp_q - 4'h1] : ~stack_pop_data;
  end
endmodule // ccfu_partner
